// *** src/tsd_defines.vh ***
`ifndef TSD_DEFINES_VH
`define TSD_DEFINES_VH
// Packet framing
`define TSD_SYNC 8'h55
`define TSD_PT_COMMON 8'h05
`define TSD_PT_RADIO_MSG 8'h09
`define TSD_RADIO_OPT_LEN 8'h0A
`define TSD_RADIO_BUF_MAX 16'h0098
`define TSD_HDR_LAST 16'h0004
`define TSD_ARG_LAST 16'h0004
`define TSD_SRC_FIRST 16'h0004
`define TSD_SRC_LAST 16'h0007
// Command codes
`define TSD_CMD_WR_BASE 8'h07
`define TSD_CMD_RD_BASE 8'h08
`define TSD_CMD_RD_DUTY 8'h23
// Result and event codes
`define TSD_RES_SUCCESS 8'h00
`define TSD_RES_FAILURE 8'h01
`define TSD_RES_NOT_SUPP 8'h02
`define TSD_RES_WRONG_PARAM 8'h03
`define TSD_RES_DUTY_LOCKED 8'h05
`define TSD_EVT_TX_COMPLETE 8'h08
// Response lengths
`define TSD_LEN_ONE 16'h0001
`define TSD_LEN_BASE 16'h0005
`define TSD_LEN_DUTY 16'h0008
`define TSD_OLEN_BASE 8'h01
`define TSD_OLEN_NONE 8'h00
// Alternative source-ID range
`define TSD_ALT_MIN 32'hFF80_0000
`define TSD_ALT_MAX 32'hFFFF_FFFE
`define TSD_ALT_MASK 32'hFFFF_FF80
`define TSD_OWN_ID_LAST 32'hFFF7_FFFF
`define TSD_ALT_BASE_RST 32'hFF80_0000
`define TSD_WRITE_CYCLES 8'hFF
// Duty monitor timing
`define TSD_CLK_NS 32'h0000_0005
`define TSD_UNIT_NS 32'h000F_4240
`define TSD_UNIT_CYCLES (`TSD_UNIT_NS / `TSD_CLK_NS)
`define TSD_SLOT_COUNT 8'h0A
`define TSD_SLOT_S 16'h0168
`define TSD_BUDGET_S 8'h24
`define TSD_BUDGET_MS 20'h0_8CA0
`define TSD_PCT_MUL 12'hB61
`define TSD_PCT_SHIFT 5'h14
`define TSD_PCT_FULL 8'h64
`endif

// *** src/tsd_tx_monitor.v ***
// Overview of operation
// - Radio message requests up to 152 buffer bytes are accepted.
// - A sendable well-formed request is answered with success once no earlier send is busy.
// - With duty lock active the request gets the lock code, no send.
// - A finished transmission sends a transmit-complete event 0x08.
// - Alternative range is refused in secure or restricted modes.
// - Alternative range has 128 addresses within FF800000..FFFFFFFE.
// - Range start always sits on a 128-address boundary.
// - Common command 0x08 reads the range start.
// - Range read answers code plus 4-byte start, then write cycles.
// - Common command 0x07 with 4-byte start writes the range start.
// - A written start is rounded down to the 128 boundary.
// - Source up to FFF7FFFF is replaced by the factory radio ID.
// - Source inside the configured range and above FFF7FFFF is sent as given.
// - Any other source is refused with a failure answer.
// - The 868 MHz variant limits transmit time to 1% per hour.
// - Ten slots of 360 s; transmit time is summed per slot.
// - Available time is 36 s minus the usage of the current slot and the last ten slots.
// - At zero available time every transmit request is locked.
// - At slot end usage is pushed as newest, oldest dropped.
// - Common command 0x23 returns used load and slot timing.
`timescale 1ns/100ps
`include "tsd_defines.vh"
module tsd_tx_monitor #(
  parameter UNIT_CYCLES = `TSD_UNIT_CYCLES
) (
  input wire CLK,
  input wire RST_N,
  input wire CE,
  input wire VARIANT_868,
  input wire ALT_ID_BLOCKED,
  input wire [31:0] FACTORY_ID,
  input wire SEC_TICK,
  input wire RX_VALID,
  input wire [7:0] RX_DATA,
  output wire RX_READY,
  output reg RSP_VALID,
  output reg [7:0] RSP_CODE,
  output reg [15:0] RSP_DLEN,
  output reg [7:0] RSP_OLEN,
  output reg [31:0] RSP_BASE,
  output reg [7:0] RSP_WR_CYCLES,
  output reg [7:0] RSP_LOAD,
  output reg [7:0] RSP_SLOTS,
  output reg [15:0] RSP_SLOT_PERIOD,
  output reg [15:0] RSP_SLOT_LEFT,
  output reg [7:0] RSP_LOAD_AFTER,
  output reg TX_START,
  output reg [31:0] TX_SRC_ID,
  output reg [15:0] TX_LEN,
  input wire TX_ACTIVE,
  input wire TX_DONE,
  output reg EVT_VALID,
  output reg [7:0] EVT_CODE,
  output wire DUTY_LOCK
);

localparam S_SYNC = 5'b00001;
localparam S_HDR = 5'b00010;
localparam S_BODY = 5'b00100;
localparam S_DCRC = 5'b01000;
localparam S_EXEC = 5'b10000;

function [7:0] crc8;
  input [7:0] c;
  input [7:0] d;
  integer i;
  reg [7:0] x;
  begin
    x = c ^ d;
    for (i = 0; i < 8; i = i + 1) begin
      x = x[7] ? ((x << 1) ^ 8'h07) : (x << 1);
    end
    crc8 = x;
  end
endfunction

function [7:0] pct;
  input [19:0] used;
  reg [31:0] p;
  begin
    p = {12'h000, used} * {20'h0_0000, `TSD_PCT_MUL};
    p = p >> `TSD_PCT_SHIFT;
    pct = (p > {24'h00_0000, `TSD_PCT_FULL}) ? `TSD_PCT_FULL : p[7:0];
  end
endfunction

////////////////////////////////////////////////////////////////////////////
// Reset release
reg rst_meta_r;
reg rst_sync_r;
wire rst_n = rst_sync_r;

always @(posedge CLK or negedge RST_N) begin
  if (!RST_N) begin
    rst_meta_r <= 1'b0;
    rst_sync_r <= 1'b0;
  end else begin
    rst_meta_r <= 1'b1;
    rst_sync_r <= rst_meta_r;
  end
end

////////////////////////////////////////////////////////////////////////////
// Duty monitor
reg [15:0] cur_r;
reg [159:0] hist_r;
reg [31:0] unit_cnt_r;
reg [15:0] sec_cnt_r;
wire [19:0] psum [0:10];
wire slot_end = SEC_TICK && (sec_cnt_r == `TSD_SLOT_S - 16'h0001);
wire [31:0] unit_last = UNIT_CYCLES - 1;

assign psum[0] = {4'h0, cur_r};
genvar g;
generate
  for (g = 0; g < 10; g = g + 1) begin : g_sum
    assign psum[g + 1] = psum[g] + {4'h0, hist_r[g * 16 +: 16]};
  end
endgenerate

wire [19:0] budget = `TSD_BUDGET_MS;
// Current slot counts against the hourly budget too
assign DUTY_LOCK = VARIANT_868 && (psum[10] >= budget);

always @(posedge CLK or negedge rst_n) begin
  if (!rst_n) begin
    cur_r <= 16'h0000;
    hist_r <= 160'h0;
    unit_cnt_r <= 32'h0000_0000;
    sec_cnt_r <= 16'h0000;
  end else if (CE) begin
    if (SEC_TICK) begin
      sec_cnt_r <= slot_end ? 16'h0000 : sec_cnt_r + 16'h0001;
    end
    if (TX_ACTIVE) begin
      unit_cnt_r <= (unit_cnt_r == unit_last) ? 32'h0000_0000
                    : unit_cnt_r + 32'h0000_0001;
    end
    if (slot_end) begin
      hist_r <= {hist_r[143:0], cur_r};
      cur_r <= 16'h0000;
    end else if (TX_ACTIVE && unit_cnt_r == unit_last
                 && cur_r != 16'hFFFF) begin
      cur_r <= cur_r + 16'h0001;
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// Packet parser
reg [4:0] st_r;
reg [15:0] idx_r;
reg [7:0] crc_r;
reg [15:0] dlen_r;
reg [7:0] olen_r;
reg [7:0] ptype_r;
reg [7:0] cmd_r;
reg [31:0] arg_r;
reg [31:0] src_r;
reg [31:0] base_r;
reg busy_r;

wire take = RX_VALID && RX_READY && CE;
wire [15:0] body_last = dlen_r + {8'h00, olen_r} - 16'h0001;
wire [15:0] opt_idx = idx_r - dlen_r;
wire [7:0] crc_nxt = crc8(crc_r, RX_DATA);
wire radio = (ptype_r == `TSD_PT_RADIO_MSG);
wire in_alt = (src_r[31:7] == base_r[31:7]) && (src_r <= `TSD_ALT_MAX);
wire exec_go = (st_r == S_EXEC) && CE && !(radio && busy_r);

assign RX_READY = (st_r != S_EXEC);

always @(posedge CLK or negedge rst_n) begin
  if (!rst_n) begin
    st_r <= S_SYNC;
    idx_r <= 16'h0000;
    crc_r <= 8'h00;
    dlen_r <= 16'h0000;
    olen_r <= 8'h00;
    ptype_r <= 8'h00;
    cmd_r <= 8'h00;
    arg_r <= 32'h0000_0000;
    src_r <= 32'h0000_0000;
  end else if (take) begin
    case (st_r)
      S_SYNC: begin
        if (RX_DATA == `TSD_SYNC) begin
          st_r <= S_HDR;
          idx_r <= 16'h0000;
          crc_r <= 8'h00;
        end
      end
      S_HDR: begin
        crc_r <= crc_nxt;
        idx_r <= idx_r + 16'h0001;
        case (idx_r[2:0])
          3'h0: dlen_r[15:8] <= RX_DATA;
          3'h1: dlen_r[7:0] <= RX_DATA;
          3'h2: olen_r <= RX_DATA;
          3'h3: ptype_r <= RX_DATA;
          default: begin
            crc_r <= 8'h00;
            idx_r <= 16'h0000;
            if (RX_DATA != crc_r) begin
              st_r <= S_SYNC;
            end else if (dlen_r == 16'h0000 && olen_r == 8'h00) begin
              st_r <= S_DCRC;
            end else begin
              st_r <= S_BODY;
            end
          end
        endcase
      end
      S_BODY: begin
        crc_r <= crc_nxt;
        idx_r <= idx_r + 16'h0001;
        if (idx_r == 16'h0000) begin
          cmd_r <= RX_DATA;
        end
        if (idx_r != 16'h0000 && idx_r <= `TSD_ARG_LAST
            && idx_r < dlen_r) begin
          arg_r <= {arg_r[23:0], RX_DATA};
        end
        if (idx_r >= dlen_r && opt_idx >= `TSD_SRC_FIRST
            && opt_idx <= `TSD_SRC_LAST) begin
          src_r <= {src_r[23:0], RX_DATA};
        end
        if (idx_r == body_last) begin
          st_r <= S_DCRC;
        end
      end
      S_DCRC: begin
        st_r <= (RX_DATA == crc_r) ? S_EXEC : S_SYNC;
      end
      default: st_r <= S_SYNC;
    endcase
  end else if (exec_go) begin
    st_r <= S_SYNC;
  end
end

////////////////////////////////////////////////////////////////////////////
// Command execution
always @(posedge CLK or negedge rst_n) begin
  if (!rst_n) begin
    base_r <= `TSD_ALT_BASE_RST;
    busy_r <= 1'b0;
    RSP_VALID <= 1'b0;
    RSP_CODE <= 8'h00;
    RSP_DLEN <= 16'h0000;
    RSP_OLEN <= 8'h00;
    RSP_BASE <= 32'h0000_0000;
    RSP_WR_CYCLES <= 8'h00;
    RSP_LOAD <= 8'h00;
    RSP_SLOTS <= 8'h00;
    RSP_SLOT_PERIOD <= 16'h0000;
    RSP_SLOT_LEFT <= 16'h0000;
    RSP_LOAD_AFTER <= 8'h00;
    TX_START <= 1'b0;
    TX_SRC_ID <= 32'h0000_0000;
    TX_LEN <= 16'h0000;
    EVT_VALID <= 1'b0;
    EVT_CODE <= 8'h00;
  end else if (CE) begin
    RSP_VALID <= exec_go;
    TX_START <= 1'b0;
    EVT_VALID <= 1'b0;
    if (TX_DONE && busy_r) begin
      busy_r <= 1'b0;
      EVT_VALID <= 1'b1;
      EVT_CODE <= `TSD_EVT_TX_COMPLETE;
    end
    if (exec_go) begin
      RSP_DLEN <= `TSD_LEN_ONE;
      RSP_OLEN <= `TSD_OLEN_NONE;
      RSP_CODE <= `TSD_RES_NOT_SUPP;
      if (radio) begin
        if (olen_r != `TSD_RADIO_OPT_LEN || dlen_r == 16'h0000
            || dlen_r > `TSD_RADIO_BUF_MAX) begin
          RSP_CODE <= `TSD_RES_WRONG_PARAM;
        end else if (DUTY_LOCK) begin
          RSP_CODE <= `TSD_RES_DUTY_LOCKED;
        end else if (src_r <= `TSD_OWN_ID_LAST
                     || (in_alt && !ALT_ID_BLOCKED)) begin
          RSP_CODE <= `TSD_RES_SUCCESS;
          TX_START <= 1'b1;
          busy_r <= 1'b1;
          TX_LEN <= dlen_r;
          TX_SRC_ID <= (src_r <= `TSD_OWN_ID_LAST) ? FACTORY_ID : src_r;
        end else begin
          RSP_CODE <= `TSD_RES_FAILURE;
        end
      end else if (ptype_r == `TSD_PT_COMMON) begin
        if (cmd_r == `TSD_CMD_RD_BASE && dlen_r == `TSD_LEN_ONE) begin
          RSP_CODE <= `TSD_RES_SUCCESS;
          RSP_DLEN <= `TSD_LEN_BASE;
          RSP_OLEN <= `TSD_OLEN_BASE;
          RSP_BASE <= base_r;
          RSP_WR_CYCLES <= `TSD_WRITE_CYCLES;
        end else if (cmd_r == `TSD_CMD_WR_BASE
                     && dlen_r == `TSD_LEN_BASE) begin
          if (arg_r < `TSD_ALT_MIN) begin
            RSP_CODE <= `TSD_RES_WRONG_PARAM;
          end else begin
            RSP_CODE <= `TSD_RES_SUCCESS;
            base_r <= arg_r & `TSD_ALT_MASK;
          end
        end else if (cmd_r == `TSD_CMD_RD_DUTY
                     && dlen_r == `TSD_LEN_ONE) begin
          RSP_CODE <= `TSD_RES_SUCCESS;
          RSP_DLEN <= `TSD_LEN_DUTY;
          RSP_LOAD <= pct(psum[10]);
          RSP_SLOTS <= `TSD_SLOT_COUNT;
          RSP_SLOT_PERIOD <= `TSD_SLOT_S;
          RSP_SLOT_LEFT <= `TSD_SLOT_S - sec_cnt_r;
          RSP_LOAD_AFTER <= pct(psum[10] - {4'h0, hist_r[159:144]});
        end
      end
    end
  end
end

endmodule

// *** testbench/tsd_tx_monitor_properties.sv ***
`timescale 1ns/100ps
module tsd_chk (
  input wire CLK,
  input wire RST_N,
  input wire VARIANT_868,
  input wire [31:0] FACTORY_ID,
  input wire RX_READY,
  input wire RSP_VALID,
  input wire [7:0] RSP_CODE,
  input wire [15:0] RSP_DLEN,
  input wire [31:0] RSP_BASE,
  input wire TX_START,
  input wire [31:0] TX_SRC_ID,
  input wire [15:0] TX_LEN,
  input wire TX_DONE,
  input wire EVT_VALID,
  input wire [7:0] EVT_CODE,
  input wire DUTY_LOCK
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  chk_done_event: assert property (
    TX_DONE |=> EVT_VALID && EVT_CODE == 8'h08)
    else $error("no complete event after radio done");
  chk_lock_no_start: assert property (
    RSP_VALID && RSP_CODE == 8'h05 |-> !TX_START)
    else $error("start issued with lock code");
  chk_start_ok: assert property (
    TX_START |-> RSP_VALID && RSP_CODE == 8'h00)
    else $error("start without success answer");
  chk_src_legal: assert property (
    TX_START |-> TX_SRC_ID == FACTORY_ID ||
      (TX_SRC_ID[31:23] == 9'h1FF && TX_SRC_ID != 32'hFFFF_FFFF))
    else $error("illegal source sent");
  chk_len_limit: assert property (
    TX_START |-> TX_LEN != 16'h0000 && TX_LEN <= 16'h0098)
    else $error("radio length out of bounds");
  chk_base_align: assert property (
    RSP_VALID && RSP_DLEN == 16'h0005 |->
      RSP_BASE[6:0] == 7'h00 && RSP_BASE[31:23] == 9'h1FF)
    else $error("range start misaligned");
  chk_lock_variant: assert property (
    DUTY_LOCK |-> VARIANT_868)
    else $error("lock outside limited variant");
  chk_rsp_after_exec: assert property (
    $rose(RSP_VALID) |-> !$past(RX_READY))
    else $error("answer without execute cycle");
  cover property (TX_START);
  cover property (RSP_VALID && RSP_CODE == 8'h05);
  cover property (EVT_VALID);
endmodule

// *** testbench/tsd_radio_model.sv ***
`timescale 1ns/100ps
module tsd_radio_model (
  input wire clk,
  input wire tx_start,
  input wire [11:0] air,
  output wire tx_active,
  output reg tx_done
);
  reg [11:0] cnt_r = 12'h000;
  initial tx_done = 1'b0;
  // Carrier stays up for the given air time, done pulses as it drops
  always @(posedge clk) begin
    tx_done <= cnt_r == 12'h001;
    if (tx_start)
      cnt_r <= air;
    else if (cnt_r != 12'h000)
      cnt_r <= cnt_r - 12'h001;
  end
  assign tx_active = cnt_r != 12'h000;
endmodule

// *** testbench/tsd_tx_monitor_tb_top.sv ***
`timescale 1ns/100ps
module tsd_tx_monitor_tb_top;
  logic CLK = 0, RST_N = 0, CE = 1, VARIANT_868 = 1, ALT_ID_BLOCKED = 0;
  logic SEC_TICK = 0, RX_VALID = 0, got, st;
  logic [7:0] RX_DATA = 8'h00;
  logic [31:0] FACTORY_ID = 32'h1234_5678, base;
  localparam int UC = 1;
  logic [11:0] air = 12'h014;
  logic [15:0] sd = 16'h2489;
  logic [7:0] q[$];
  int mismatches = 0, cmp_count = 0, used = 0;
  wire RX_READY, RSP_VALID, TX_START, EVT_VALID, DUTY_LOCK, TX_ACTIVE, TX_DONE;
  wire [7:0] RSP_CODE, RSP_OLEN, RSP_WR_CYCLES, RSP_LOAD, RSP_SLOTS, EVT_CODE;
  wire [7:0] RSP_LOAD_AFTER;
  wire [15:0] RSP_DLEN, RSP_SLOT_PERIOD, RSP_SLOT_LEFT, TX_LEN;
  wire [31:0] RSP_BASE, TX_SRC_ID;
  always #2.5 CLK = ~CLK;
  tsd_tx_monitor #(.UNIT_CYCLES(UC)) DUT (.*);
  tsd_radio_model u_radio (.clk(CLK), .tx_start(TX_START), .air(air),
    .tx_active(TX_ACTIVE), .tx_done(TX_DONE));
  ////////////////////////////////////////////////////////////////////////
  function automatic [15:0] lf(input [15:0] s);
    lf = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Used load in percent of the hourly budget, capped at full
  function automatic int ld(input int u);
    ld = (u / 360 > 100) ? 100 : u / 360;
  endfunction
  function automatic [7:0] crc(input [7:0] c, input [7:0] b);
    c = c ^ b;
    repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    crc = c;
  endfunction
  task cy;
    @(posedge CLK);
    #1;
  endtask
  task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task sb(input [7:0] b);
    RX_VALID = 1;
    RX_DATA = b;
    while (RX_READY !== 1'b1) cy;
    cy;
  endtask
  task pkt(input [7:0] typ, input [7:0] ol, input bad);
    logic [15:0] n;
    logic [7:0] c;
    n = 16'(q.size()) - {8'h00, ol};
    c = crc(crc(crc(crc(8'h00, n[15:8]), n[7:0]), ol), typ);
    sb(8'h55);
    sb(n[15:8]);
    sb(n[7:0]);
    sb(ol);
    sb(typ);
    sb(c);
    c = 8'h00;
    foreach (q[i]) begin
      sb(q[i]);
      c = crc(c, q[i]);
    end
    sb(c ^ {7'h00, bad});
    RX_VALID = 0;
    got = 0;
    st = 0;
    repeat (40) if (!got) begin
      cy;
      got = RSP_VALID;
      st = TX_START;
    end
    // Host holds off until the send has finished
    if (st === 1'b1) begin
      used = used + air / UC;
      repeat (air + 40) if (EVT_VALID !== 1'b1) cy;
      cmp("event valid", 1'b1, EVT_VALID);
      cmp("event", 8'h08, EVT_CODE);
    end
  endtask
  task cmd(input [7:0] c, input [31:0] a, input w);
    q = {c};
    if (w) q = {q, a[31:24], a[23:16], a[15:8], a[7:0]};
    pkt(8'h05, 8'h00, 0);
  endtask
  task radio(input [31:0] s, input [15:0] n, input [7:0] ec, input [31:0] es);
    q = {};
    repeat (n) begin
      sd = lf(sd);
      q.push_back(sd[7:0]);
    end
    q = {q, 8'hFF, 8'hFF, 8'hFF, 8'hFF, s[31:24], s[23:16], s[15:8], s[7:0]};
    q = {q, 8'hFF, 8'h00};
    pkt(8'h09, 8'h0A, 0);
    cmp("tx answer", 1'b1, got);
    cmp("tx code", ec, RSP_CODE);
    cmp("tx start", ec == 8'h00, st);
    if (st === 1'b1) begin
      cmp("tx src", es, TX_SRC_ID);
      cmp("tx len", n, TX_LEN);
    end
  endtask
  task ticks(input int n);
    repeat (n) begin
      SEC_TICK = 1;
      cy;
      SEC_TICK = 0;
      cy;
    end
  endtask
  task stop_test;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #400_000;
    mismatches++;
    stop_test;
  end
  initial begin
    repeat (12) @(posedge CLK);
    #1 RST_N = 1;
    repeat (3) cy;
    cmd(8'h08, 32'h0000_0000, 0);
    cmp("rd len", 16'h0005, RSP_DLEN);
    cmp("rd olen", 8'h01, RSP_OLEN);
    cmp("rd base", 32'hFF80_0000, RSP_BASE);
    cmp("rd cycles", 8'hFF, RSP_WR_CYCLES);
    sd = lf(sd);
    // Range sits above the span that gets the factory ID, with no wrap
    base = {13'h1FFF, 1'b0, sd[10:0], 7'h5A};
    cmd(8'h07, base, 1);
    cmp("wr code", 8'h00, RSP_CODE);
    cmd(8'h07, 32'hFF7F_FFFF, 1);
    cmp("wr low", 8'h03, RSP_CODE);
    base = base & 32'hFFFF_FF80;
    cmd(8'h08, 32'h0000_0000, 0);
    cmp("base", base, RSP_BASE);
    ALT_ID_BLOCKED = 1;
    radio(base, 16'h0004, 8'h01, 32'h0000_0000);
    ALT_ID_BLOCKED = 0;
    radio(32'h0000_0000, 16'h0098, 8'h00, FACTORY_ID);
    radio(32'hFFF7_FFFF, 16'h0001, 8'h00, FACTORY_ID);
    sd = lf(sd);
    radio(base + sd[6:0], {8'h00, sd[15:8] % 8'h98} + 16'h0001, 8'h00,
      base + sd[6:0]);
    radio(base + 32'h0000_0080, 16'h0004, 8'h01, 32'h0);
    radio(32'h0000_0000, 16'h0099, 8'h03, 32'h0000_0000);
    q = {8'h08};
    pkt(8'h05, 8'h00, 1);
    cmp("bad crc", 1'b0, got);
    cmd(8'h23, 32'h0000_0000, 0);
    cmp("slots", 8'h0A, RSP_SLOTS);
    cmp("period", 16'h0168, RSP_SLOT_PERIOD);
    cmp("slot left", 16'h0168, RSP_SLOT_LEFT);
    cmp("load", ld(used), RSP_LOAD);
    air = 12'hFA0;
    repeat (10) radio(32'h0, 16'h0008, used >= 36000 ? 8'h05 : 8'h00,
      FACTORY_ID);
    cmp("locked", 1'b1, DUTY_LOCK);
    VARIANT_868 = 0;
    cy;
    cmp("lock variant", 1'b0, DUTY_LOCK);
    VARIANT_868 = 1;
    ticks(3600);
    cmp("lock held", 1'b1, DUTY_LOCK);
    cmd(8'h23, 32'h0000_0000, 0);
    cmp("load full", ld(used), RSP_LOAD);
    cmp("load after", ld(0), RSP_LOAD_AFTER);
    ticks(360);
    cmp("lock free", 1'b0, DUTY_LOCK);
    radio(32'h0000_0000, 16'h0008, 8'h00, FACTORY_ID);
    cmd(8'h23, 32'h0000_0000, 0);
    cmp("load new", ld(air / UC), RSP_LOAD);
    RST_N = 0;
    cy;
    RST_N = 1;
    repeat (3) cy;
    cmd(8'h23, 32'h0000_0000, 0);
    cmp("load reset", ld(0), RSP_LOAD);
    cmd(8'h08, 32'h0000_0000, 0);
    cmp("base reset", 32'hFF80_0000, RSP_BASE);
    stop_test;
  end
endmodule
bind tsd_tx_monitor tsd_chk u_chk (.*);
